// ---- rtl/p2er_bank.sv ----
/*
  Port 2 egress rate register, PHY special control/status register,
  interrupt status/mask and config, on an APB slave; two queue shapers.
  Assumes PHY status inputs and queue strobes come from logic on clk_sys.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "p2er_params.svh"
module p2er_bank #(
  parameter int ADDR_W   = 16,
  parameter int CREDIT_W = 20
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                linkSpeed100,
  input  wire logic [1:0]          queueByteSent,
  output logic      [1:0]          queueAllow,
  input  wire logic                cableTestBusy,
  input  wire p2er_pkg::p2er_cable_e cableResult,
  input  wire logic                cableShort10,
  input  wire logic [8:0]          cableFaultCount,
  output logic                     forceLinkPass,
  output logic                     powerSaveEn,
  output logic                     remoteLoopback,
  output logic                     irq
);
  import p2er_pkg::*;

  generate
    if (ADDR_W < 13) begin : g_bad_addr
      $error("p2er_bank: ADDR_W cannot reach the register map");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_EGRESS = ADDR_W'({`P2ER_IDX_EGRESS, 2'b00});
  localparam logic [ADDR_W-1:0] A_PHY    = ADDR_W'({`P2ER_IDX_PHY, 2'b00});
  localparam logic [ADDR_W-1:0] A_ISTAT  = ADDR_W'({`P2ER_IDX_ISTAT, 2'b00});
  localparam logic [ADDR_W-1:0] A_IMASK  = ADDR_W'({`P2ER_IDX_IMASK, 2'b00});
  localparam logic [ADDR_W-1:0] A_CFG    = ADDR_W'({`P2ER_IDX_CFG, 2'b00});

  logic setup;
  logic wrEn;
  logic hitEgress;
  logic hitPhy;
  logic hitStat;
  logic hitMask;
  logic hitCfg;
  logic hitAny;

  assign setup     = psel && !penable;
  assign wrEn      = psel && penable && pwrite;
  assign hitEgress = (paddr == A_EGRESS);
  assign hitPhy    = (paddr == A_PHY);
  assign hitStat   = (paddr == A_ISTAT);
  assign hitMask   = (paddr == A_IMASK);
  assign hitCfg    = (paddr == A_CFG);
  assign hitAny    = hitEgress || hitPhy || hitStat || hitMask || hitCfg;
  // Read data is registered in setup, so every access ends in one cycle
  assign pready    = 1'b1;

  // ----------------------------------------------------------------------
  // Egress rate register
  // ----------------------------------------------------------------------
  logic [7:0] egressReg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      egressReg <= `P2ER_EGRESS_RST;
    end else if (wrEn && hitEgress) begin
      egressReg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // PHY special control bits
  // ----------------------------------------------------------------------
  logic [1:0] phyCtrl;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phyCtrl <= `P2ER_PHY_CTRL_RST;
    end else if (wrEn && hitPhy) begin
      phyCtrl <= {pwdata[`P2ER_POWER_SAVE], pwdata[`P2ER_LOOPBACK]};
    end
  end

  assign powerSaveEn    = !phyCtrl[1];
  assign remoteLoopback = phyCtrl[0];

  // Pulse only; the bit itself is never stored, so it reads back zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      forceLinkPass <= 1'b0;
    end else begin
      forceLinkPass <= wrEn && hitPhy && pwdata[`P2ER_FORCE_LINK];
    end
  end

  // ----------------------------------------------------------------------
  // Config register
  // ----------------------------------------------------------------------
  logic multiQueue;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      multiQueue <= `P2ER_CFG_RST;
    end else if (wrEn && hitCfg) begin
      multiQueue <= pwdata[`P2ER_CFG_MULTIQ];
    end
  end

  // ----------------------------------------------------------------------
  // Cable test events and interrupt
  // ----------------------------------------------------------------------
  logic       busyPrev;
  logic [1:0] events;
  logic [1:0] intStat;
  logic [1:0] intMask;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busyPrev <= 1'b0;
    end else begin
      busyPrev <= cableTestBusy;
    end
  end

  assign events[`P2ER_EV_DONE]  = busyPrev && !cableTestBusy;
  assign events[`P2ER_EV_FAULT] = busyPrev && !cableTestBusy
                                  && (cableResult != P2ER_CABLE_NORMAL);

  // A set in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      intStat <= 2'b00;
    end else if (wrEn && hitStat) begin
      intStat <= (intStat & ~pwdata[1:0]) | events;
    end else begin
      intStat <= intStat | events;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      intMask <= 2'b00;
    end else if (wrEn && hitMask) begin
      intMask <= pwdata[1:0];
    end
  end

  assign irq = |(intStat & intMask);

  // ----------------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hitEgress) begin
      next_prdata[7:0] = egressReg;
    end else if (hitPhy) begin
      next_prdata[`P2ER_NEAR_SHORT] = cableShort10;
      next_prdata[`P2ER_RESULT_LSB +: 2] = cableResult;
      next_prdata[`P2ER_BUSY] = cableTestBusy;
      next_prdata[`P2ER_POWER_SAVE] = phyCtrl[1];
      next_prdata[`P2ER_LOOPBACK] = phyCtrl[0];
      next_prdata[8:0] = cableFaultCount;
    end else if (hitStat) begin
      next_prdata[1:0] = intStat;
    end else if (hitMask) begin
      next_prdata[1:0] = intMask;
    end else if (hitCfg) begin
      next_prdata[`P2ER_CFG_MULTIQ] = multiQueue;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= next_prdata;
      pslverr <= !hitAny;
    end
  end

  // ----------------------------------------------------------------------
  // Effective codes and shapers
  // ----------------------------------------------------------------------
  p2er_shp_if shp0 ();
  p2er_shp_if shp1 ();

  function automatic p2er_rate_t slow_limit(input p2er_rate_t code, input logic fast);
    // Codes of 16 Mbps and up exceed a 10 Mbps port
    if (!fast && code >= `P2ER_FAST_CODE_MIN) begin
      slow_limit = 4'h0;
    end else begin
      slow_limit = code;
    end
  endfunction

  assign shp0.effCode  = slow_limit(egressReg[`P2ER_PRIO0_LSB +: 4], linkSpeed100);
  assign shp1.effCode  = multiQueue
                         ? slow_limit(egressReg[`P2ER_PRIO1_LSB +: 4], linkSpeed100)
                         : 4'h0;
  assign shp0.byteSent = queueByteSent[0];
  assign shp1.byteSent = queueByteSent[1];
  assign queueAllow    = {shp1.allow, shp0.allow};

  p2er_shaper #(.CREDIT_W(CREDIT_W)) u_shp0 (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .link    (shp0.shp)
  );

  p2er_shaper #(.CREDIT_W(CREDIT_W)) u_shp1 (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .link    (shp1.shp)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_phy_write_force;
    psel && penable && pwrite && hitPhy && pwdata[`P2ER_FORCE_LINK];
  endsequence

  sequence s_phy_read_setup;
    setup && !pwrite && hitPhy;
  endsequence

  a_prio1_code_store: assert property (@(posedge clk_sys) disable iff (!resetn)
    wrEn && hitEgress |=> egressReg[7:4] == $past(pwdata[7:4]))
    else $error("prio1 code not stored");

  a_rate_code_table: assert property (@(posedge clk_sys) disable iff (!resetn)
    shp0.effCode == 4'hA |-> shp0.rateKbps == 17'h0_7D00 && shp0.allow == !u_shp0.credit[CREDIT_W-1])
    else $error("rate code 1010 not 32 Mbps");

  a_prio0_code_store: assert property (@(posedge clk_sys) disable iff (!resetn)
    wrEn && hitEgress |=> shp0.effCode == ($past(linkSpeed100) || $past(pwdata[3:0]) < 4'h9
                          ? $past(pwdata[3:0]) : 4'h0) || $changed(linkSpeed100))
    else $error("prio0 code not applied");

  a_unlimited_allows: assert property (@(posedge clk_sys) disable iff (!resetn)
    shp1.effCode == 4'h0 |-> queueAllow[1])
    else $error("unlimited queue stalled");

  a_slow_port_fast: assert property (@(posedge clk_sys) disable iff (!resetn)
    !linkSpeed100 && egressReg[3:0] >= 4'h9 |-> shp0.effCode == 4'h0 && queueAllow[0])
    else $error("fast code limits 10 Mbps port");

  a_single_queue: assert property (@(posedge clk_sys) disable iff (!resetn)
    !multiQueue |-> shp1.effCode == 4'h0)
    else $error("prio1 limited in single queue mode");

  a_cable_status_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_phy_read_setup |=> prdata[15] == $past(cableShort10) && prdata[14:13] == $past(cableResult))
    else $error("cable status misread");

  a_busy_distance_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_phy_read_setup |=> prdata[12] == $past(cableTestBusy) && prdata[8:0] == $past(cableFaultCount))
    else $error("busy or distance misread");

  a_force_link_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_phy_write_force ##1 !wrEn |-> forceLinkPass ##1 !forceLinkPass)
    else $error("force link not a single pulse");

  a_power_loop_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    wrEn && hitPhy |=> powerSaveEn == !$past(pwdata[10]) && remoteLoopback == $past(pwdata[9]))
    else $error("power save or loopback not updated");
endmodule // p2er_bank
`default_nettype wire

// ---- rtl/p2er_params.svh ----
/*
  Offsets, field positions, reset values and timing counts of the port 2
  egress rate and PHY special control block.
  Assumes inclusion by bare name from rtl/ and test/ files.
*/
`ifndef P2ER_PARAMS_SVH
`define P2ER_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define P2ER_IDX_EGRESS    16'h052A
`define P2ER_IDX_PHY       16'h0530
`define P2ER_IDX_ISTAT     16'h0540
`define P2ER_IDX_IMASK     16'h0541
`define P2ER_IDX_CFG       16'h0542

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define P2ER_PRIO1_LSB     4
`define P2ER_PRIO0_LSB     0
`define P2ER_NEAR_SHORT    15
`define P2ER_RESULT_LSB    13
`define P2ER_BUSY          12
`define P2ER_FORCE_LINK    11
`define P2ER_POWER_SAVE    10
`define P2ER_LOOPBACK      9
`define P2ER_EV_DONE       0
`define P2ER_EV_FAULT      1
`define P2ER_CFG_MULTIQ    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define P2ER_EGRESS_RST    8'h00
`define P2ER_PHY_CTRL_RST  2'b10
`define P2ER_CFG_RST       1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define P2ER_CLK_HZ        10000000
`define P2ER_BITS_PER_BYTE 8
`define P2ER_FAST_CODE_MIN 4'h9

`endif

// ---- rtl/p2er_pkg.sv ----
/*
  Types shared by the egress rate and PHY special control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package p2er_pkg;
  typedef logic [3:0]  p2er_rate_t;
  typedef logic [16:0] p2er_kbps_t;
  typedef enum logic [1:0] {
    P2ER_CABLE_NORMAL,
    P2ER_CABLE_OPEN,
    P2ER_CABLE_SHORT,
    P2ER_CABLE_FAILED
  } p2er_cable_e;
endpackage

// ---- rtl/p2er_shp_if.sv ----
/*
  Link between the register bank and one egress queue shaper.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface p2er_shp_if;
  import p2er_pkg::*;
  p2er_rate_t effCode;
  logic       byteSent;
  logic       allow;
  p2er_kbps_t rateKbps;
  modport ctl (output effCode, output byteSent, input allow, input rateKbps);
  modport shp (input effCode, input byteSent, output allow, output rateKbps);
endinterface
`default_nettype wire

// ---- rtl/p2er_shaper.sv ----
/*
  Credit based shaper for one egress priority queue.
  Assumes the queue sends at most one byte per cycle and pulses byteSent.
*/
`timescale 1ns/10ps
`default_nettype none
`include "p2er_params.svh"
module p2er_shaper #(
  parameter int CREDIT_W = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  p2er_shp_if.shp  link
);
  import p2er_pkg::*;

  // ----------------------------------------------------------------------
  // Rate decode and credit constants
  // ----------------------------------------------------------------------
  // Credit is in units of 1e-4 bit; one kbps adds one unit per cycle at 10 MHz
  localparam int COST = `P2ER_BITS_PER_BYTE * (`P2ER_CLK_HZ / 1000);
  localparam int CAP  = 2 * COST;

  generate
    if (CREDIT_W < 20) begin : g_bad_width
      $error("p2er_shaper: CREDIT_W too narrow for byte cost");
    end
  endgenerate

  function automatic p2er_kbps_t rate_of(input p2er_rate_t code);
    case (code)
      4'h1:    rate_of = 17'h0_0040;
      4'h2:    rate_of = 17'h0_0080;
      4'h3:    rate_of = 17'h0_0100;
      4'h4:    rate_of = 17'h0_0200;
      4'h5:    rate_of = 17'h0_03E8;
      4'h6:    rate_of = 17'h0_07D0;
      4'h7:    rate_of = 17'h0_0FA0;
      4'h8:    rate_of = 17'h0_1F40;
      4'h9:    rate_of = 17'h0_3E80;
      4'hA:    rate_of = 17'h0_7D00;
      4'hB:    rate_of = 17'h0_BB80;
      4'hC:    rate_of = 17'h0_FA00;
      4'hD:    rate_of = 17'h1_1940;
      4'hE:    rate_of = 17'h1_3880;
      4'hF:    rate_of = 17'h1_57C0;
      default: rate_of = 17'h0_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Credit bucket
  // ----------------------------------------------------------------------
  logic signed [CREDIT_W-1:0] credit;
  logic signed [CREDIT_W:0]   sum;

  assign link.rateKbps = rate_of(link.effCode);

  always_comb begin
    sum = {credit[CREDIT_W-1], credit} + $signed({1'b0, link.rateKbps});
    if (link.byteSent) begin
      sum = sum - $signed((CREDIT_W+1)'(COST));
    end
  end

  // Bounded burst so an idle queue cannot bank unlimited credit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      credit <= '0;
    end else if (link.rateKbps == '0) begin
      credit <= '0;
    end else if (sum > $signed((CREDIT_W+1)'(CAP))) begin
      credit <= CREDIT_W'(CAP);
    end else begin
      credit <= sum[CREDIT_W-1:0];
    end
  end

  // Stalls the queue instead of dropping its frames
  assign link.allow = (link.rateKbps == '0) || !credit[CREDIT_W-1];
endmodule // p2er_shaper
`default_nettype wire

// ---- test/p2er_bank_test.sv ----
/*
  Self-checking bench for the port 2 egress rate and PHY special control bank.
  Assumes the rtl/ files are compiled first; the bench is the APB master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "p2er_params.svh"
module p2er_bank_test;
  import p2er_pkg::*;
  // --------
  // Signals
  // --------
  localparam int WIN = 2000;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [12:0] cab;
    logic [31:0] exp;
    logic [1:0]  outs;
  } p2er_row_s;
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        linkSpeed100;
  logic [1:0]  queueByteSent;
  logic [1:0]  queueAllow;
  logic        cableTestBusy;
  p2er_cable_e cableResult;
  logic        cableShort10;
  logic [8:0]  cableFaultCount;
  logic        forceLinkPass;
  logic        powerSaveEn;
  logic        remoteLoopback;
  logic        irq;
  logic        sendEn;
  logic        countEn;
  logic        lastErr;
  logic [31:0] rd;
  int          byteCount [2];
  int          checks;
  int          failCount;
  int          kbps [16] = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000,
                             32000, 48000, 64000, 72000, 80000, 88000};
  p2er_row_s   rows [5] = '{
    '{`P2ER_IDX_EGRESS, 32'hFFFF_FFA5, 13'h0000, 32'h0000_00A5, 2'b00},
    '{`P2ER_IDX_EGRESS, 32'h0000_0000, 13'h0000, 32'h0000_0000, 2'b00},
    '{`P2ER_IDX_PHY,    32'h0000_0000, 13'h17FF, 32'h0000_B1FF, 2'b10},
    '{`P2ER_IDX_PHY,    32'h0000_0600, 13'h08AA, 32'h0000_46AA, 2'b01},
    '{`P2ER_IDX_PHY,    32'h0000_0200, 13'h0D55, 32'h0000_6355, 2'b11}};

  p2er_bank dut (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkSpeed100(linkSpeed100),
    .queueByteSent(queueByteSent), .queueAllow(queueAllow),
    .cableTestBusy(cableTestBusy), .cableResult(cableResult),
    .cableShort10(cableShort10), .cableFaultCount(cableFaultCount),
    .forceLinkPass(forceLinkPass), .powerSaveEn(powerSaveEn),
    .remoteLoopback(remoteLoopback), .irq(irq));

  // --------
  // Tasks
  // --------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Lagging greedy sender overshoots a little, hence the slack
  task automatic chkNear(input string name, input int seen, input int exp);
    chk(name, 32'((seen - exp <= 4 && exp - seen <= 4) ? exp : seen), 32'(exp));
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 16'(idx << 2);
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failCount++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
  endtask

  function automatic int expn(input int r);
    return (r == 0 || WIN * r / 80000 > WIN) ? WIN : WIN * r / 80000;
  endfunction

  task automatic shape(input logic [3:0] c1, input logic [3:0] c0, input int e1, input int e0);
    apb(1'b1, `P2ER_IDX_EGRESS, {24'h00_0000, c1, c0});
    sendEn <= 1'b1;
    repeat (50) @(posedge clk_sys);
    countEn <= 1'b1;
    repeat (WIN) @(posedge clk_sys);
    countEn <= 1'b0;
    sendEn <= 1'b0;
    @(posedge clk_sys);
    chkNear("prio1 bytes", byteCount[1], e1);
    chkNear("prio0 bytes", byteCount[0], e0);
  endtask

  task automatic cableRun(input p2er_cable_e r);
    cableResult <= r;
    cableTestBusy <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cableTestBusy <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // --------
  // Clock, sender, watchdog
  // --------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    queueByteSent <= sendEn ? queueAllow : 2'b00;
    for (int k = 0; k < 2; k++)
      byteCount[k] <= countEn ? byteCount[k] + int'(queueByteSent[k]) : 0;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end

  // --------
  // Main sequence
  // --------
  initial begin
    int n;
    {resetn, psel, penable, pwrite, sendEn, countEn} = '0;
    {paddr, pwdata, cableTestBusy, cableShort10, cableFaultCount} = '0;
    cableResult = P2ER_CABLE_NORMAL;
    linkSpeed100 = 1'b1;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    chk("allow", queueAllow, 2'b11);
    chk("pins", {powerSaveEn, remoteLoopback, irq}, 3'b000);
    apb(1'b0, `P2ER_IDX_EGRESS, 0);
    chk("egress rst", rd, 32'h0000_0000);
    apb(1'b0, `P2ER_IDX_PHY, 0);
    chk("phy rst", rd, 32'h0000_0400);
    apb(1'b0, 16'h0543, 0);
    chk("unmapped", {rd[30:0], lastErr}, 32'h0000_0001);
    foreach (rows[i]) begin
      cableTestBusy <= rows[i].cab[12];
      cableResult <= p2er_cable_e'(rows[i].cab[11:10]);
      cableShort10 <= rows[i].cab[9];
      cableFaultCount <= rows[i].cab[8:0];
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 0);
      chk("reg", rd, rows[i].exp);
      chk("pins", {powerSaveEn, remoteLoopback}, rows[i].outs);
    end
    // Force link is a pulse; the bit is not stored and must read back zero
    apb(1'b1, `P2ER_IDX_PHY, 32'h0000_0C00);
    n = 0;
    repeat (5) begin
      @(posedge clk_sys);
      n += int'(forceLinkPass);
    end
    chk("force pulses", 32'(n), 32'h0000_0001);
    apb(1'b0, `P2ER_IDX_PHY, 0);
    chk("force bit", rd & 32'h0000_0E00, 32'h0000_0400);
    // Cable test done and fault events
    apb(1'b1, `P2ER_IDX_ISTAT, 32'h0000_0003);
    apb(1'b1, `P2ER_IDX_IMASK, 32'h0000_0000);
    cableRun(P2ER_CABLE_OPEN);
    apb(1'b0, `P2ER_IDX_ISTAT, 0);
    chk("istat", rd, 32'h0000_0003);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, `P2ER_IDX_IMASK, 32'h0000_0002);
    @(posedge clk_sys);
    chk("irq", irq, 1'b1);
    apb(1'b1, `P2ER_IDX_ISTAT, 32'h0000_0002);
    @(posedge clk_sys);
    chk("irq clr", irq, 1'b0);
    apb(1'b0, `P2ER_IDX_ISTAT, 0);
    chk("istat w1c", rd, 32'h0000_0001);
    apb(1'b1, `P2ER_IDX_ISTAT, 32'h0000_0001);
    cableRun(P2ER_CABLE_NORMAL);
    apb(1'b0, `P2ER_IDX_ISTAT, 0);
    chk("istat normal", rd, 32'h0000_0001);
    // Shaping across every code, both queues at once
    for (int i = 1; i < 16; i++)
      shape(4'(16 - i), 4'(i), expn(kbps[16 - i]), expn(kbps[i]));
    linkSpeed100 <= 1'b0;
    shape(4'h8, 4'h9, expn(8000), WIN);
    shape(4'hA, 4'h3, WIN, expn(256));
    linkSpeed100 <= 1'b1;
    apb(1'b1, `P2ER_IDX_CFG, 32'h0000_0000);
    shape(4'h1, 4'h1, WIN, expn(64));
    shape(4'h0, 4'h2, WIN, expn(128));
    // Reset in mid-run restores defaults
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b0, `P2ER_IDX_PHY, 0);
    chk("phy rst2", rd, 32'h0000_0555);
    apb(1'b0, `P2ER_IDX_EGRESS, 0);
    chk("egress rst2", rd, 32'h0000_0000);
    apb(1'b0, `P2ER_IDX_CFG, 0);
    chk("cfg rst2", rd, 32'h0000_0001);
    final_report();
  end
endmodule // p2er_bank_test
`default_nettype wire
